// ### src/dpbr_pkg.sv
// shared constants and types of the dual-port block memory
package dpbr_pkg;

   // storage: 1024 words of 36 bits form the 36Kb array
   localparam int DATA_W = 36;
   localparam int ADDR_W = 10;

   // register byte offsets on the control bus
   localparam int REG_AW = 12;
   localparam logic [REG_AW-1:0] REG_CTRL = 12'h000;
   localparam logic [REG_AW-1:0] REG_STATUS = 12'h004;
   localparam logic [REG_AW-1:0] REG_COLL_ADDR = 12'h008;

   // control register field positions
   localparam int CTRL_SPLIT = 0;
   localparam int CTRL_SLEEP = 1;
   localparam int CTRL_LATCH_A = 2;
   localparam int CTRL_LATCH_B = 3;
   localparam int CTRL_PIPE_A = 4;
   localparam int CTRL_PIPE_B = 5;
   localparam int CTRL_WM_A = 6;
   localparam int CTRL_WM_B = 8;
   localparam int CTRL_CASC_A = 10;
   localparam int CTRL_CASC_B = 11;
   localparam int CTRL_BITS = 12;
   localparam logic [CTRL_BITS-1:0] CTRL_RST = 12'h00c;

   // status register field positions
   localparam int STAT_SLEEP = 0;
   localparam int STAT_COLL = 1;
   localparam int STAT_SPLIT = 2;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // read-out policy of a port during its own write
   typedef enum logic [1:0] {
      DPBR_WM_WRITE_FIRST = 2'h0,
      DPBR_WM_READ_FIRST = 2'h1,
      DPBR_WM_NO_CHANGE = 2'h2
   } dpbr_wmode_t;

   // one port request; upper selects the cascaded neighbour
   typedef struct packed {
      logic en;
      logic we;
      logic upper;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] din;
   } dpbr_req_t;

   // per-port configuration handed to a port stage
   typedef struct packed {
      logic latch;
      logic pipe;
      logic casc;
   } dpbr_pcfg_t;

endpackage : dpbr_pkg

// ### src/dpbr_mem.sv
// storage array with two synchronous access ports
`timescale 1ns/10ps
module dpbr_mem
   import dpbr_pkg::*;
#(
   parameter int DW = DATA_W,
   parameter int AW = ADDR_W
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sleep,
   input wire logic en_a,
   input wire logic we_a,
   input wire logic [AW-1:0] addr_a,
   input wire logic [DW-1:0] din_a,
   input wire dpbr_wmode_t wm_a,
   input wire logic en_b,
   input wire logic we_b,
   input wire logic [AW-1:0] addr_b,
   input wire logic [DW-1:0] din_b,
   input wire dpbr_wmode_t wm_b,
   output logic [DW-1:0] dout_a,
   output logic [DW-1:0] dout_b
);

   if (DW < 1 || DW > 72 || AW < 2 || AW > 16) begin : g_chk
      $error("dpbr_mem: unsupported width or depth");
   end

   typedef struct packed {
      logic [DW-1:0] da;
      logic [DW-1:0] db;
   } st_t;

   logic [DW-1:0] mem [0:(2**AW)-1];
   st_t st;
   st_t next_st;

   // read data always leave from a register
   function automatic logic [DW-1:0] rd_sel(
      input logic we, input dpbr_wmode_t wm, input logic [DW-1:0] old,
      input logic [DW-1:0] din, input logic [DW-1:0] held);
      logic [DW-1:0] r;
      r = old;
      if (we) begin
         unique case (wm)
            DPBR_WM_WRITE_FIRST: r = din;
            DPBR_WM_READ_FIRST: r = old;
            DPBR_WM_NO_CHANGE: r = held;
            default: r = held;
         endcase
      end
      return r;
   endfunction : rd_sel

   always_comb begin
      next_st = st;
      if (!sleep && en_a) begin
         next_st.da = rd_sel(we_a, wm_a, mem[addr_a], din_a, st.da);
      end
      if (!sleep && en_b) begin
         next_st.db = rd_sel(we_b, wm_b, mem[addr_b], din_b, st.db);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // port a written last, so on a same-word clash it decides
   always_ff @(posedge clk) begin
      if (!sleep && en_b && we_b) begin
         mem[addr_b] <= din_b;
      end
      if (!sleep && en_a && we_a) begin
         mem[addr_a] <= din_a;
      end
   end

   assign dout_a = st.da;
   assign dout_b = st.db;

endmodule : dpbr_mem

// ### src/dpbr_port.sv
// input register, address latch and output stage of one port
`timescale 1ns/10ps
module dpbr_port
   import dpbr_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire dpbr_pcfg_t cfg,
   input wire dpbr_req_t req,
   input wire logic [DATA_W-1:0] mem_dout,
   input wire logic [DATA_W-1:0] casc_din,
   output dpbr_req_t mem_req,
   output dpbr_req_t casc_req,
   output logic [DATA_W-1:0] dout
);

   typedef struct packed {
      dpbr_req_t rq;
      logic up_rd;
      logic up_pipe;
      logic [DATA_W-1:0] dpipe;
   } st_t;

   st_t st;
   st_t next_st;

   always_comb begin
      next_st = st;
      // every input is captured before it touches the array
      next_st.rq.en = req.en;
      next_st.rq.we = req.we;
      next_st.rq.din = req.din;
      // latched address only moves on an enabled cycle
      if (!cfg.latch || req.en) begin
         next_st.rq.addr = req.addr;
         next_st.rq.upper = req.upper;
      end
      next_st.up_rd = st.rq.upper;
      next_st.up_pipe = st.up_rd;
      next_st.dpipe = mem_dout;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // upper half of a cascaded pair goes to the neighbour
   always_comb begin
      mem_req = st.rq;
      casc_req = st.rq;
      mem_req.en = st.rq.en && !(cfg.casc && st.rq.upper);
      casc_req.en = st.rq.en && cfg.casc && st.rq.upper;
   end

   // neighbour must use the same pipeline setting to line up
   always_comb begin
      if (cfg.pipe) begin
         dout = (cfg.casc && st.up_pipe) ? casc_din : st.dpipe;
      end else begin
         dout = (cfg.casc && st.up_rd) ? casc_din : mem_dout;
      end
   end

endmodule : dpbr_port

// ### src/dpbr_top.sv
// dual-port block memory with its control registers
`timescale 1ns/10ps
// Contract
// - two ports with separate controls share only the storage array
// - one 36Kb array or two independent 18Kb halves
// - all reads and writes happen on a clock edge, none asynchronously
// - data, address, enable and write enable are registered first
// - address register holds between operations unless latching is off
// - optional output pipeline adds one cycle of read latency
// - write-time read-out: old data, new data or unchanged
// - cascade links to neighbouring blocks build deeper arrays
// - power gating input can put the array to sleep
module dpbr_top
   import dpbr_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [REG_AW-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [REG_AW-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sleep_in,
   input wire dpbr_req_t req_a,
   output logic [DATA_W-1:0] dout_a,
   input wire dpbr_req_t req_b,
   output logic [DATA_W-1:0] dout_b,
   input wire logic [DATA_W-1:0] casc_din_a,
   input wire logic [DATA_W-1:0] casc_din_b,
   output dpbr_req_t casc_req_a,
   output dpbr_req_t casc_req_b,
   output logic sleep_active
);

   typedef struct packed {
      logic aw_full;
      logic [REG_AW-1:0] aw_addr;
      logic w_full;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [CTRL_BITS-1:0] ctrl;
      logic coll;
      logic [ADDR_W-1:0] coll_addr;
      logic sleep_q;
   } st_t;

   st_t st;
   st_t next_st;

   dpbr_pcfg_t cfg_a;
   dpbr_pcfg_t cfg_b;
   dpbr_req_t mreq_a;
   dpbr_req_t mreq_b;
   logic [ADDR_W-1:0] addr_a;
   logic [ADDR_W-1:0] addr_b;
   logic [DATA_W-1:0] mdout_a;
   logic [DATA_W-1:0] mdout_b;
   logic sleep_now;
   logic wr_go;
   logic ar_go;
   logic clash;
   logic [31:0] ctrl_word;
   logic [31:0] stat_word;
   logic [31:0] wmask;

   assign cfg_a.latch = st.ctrl[CTRL_LATCH_A];
   assign cfg_a.pipe = st.ctrl[CTRL_PIPE_A];
   assign cfg_a.casc = st.ctrl[CTRL_CASC_A];
   assign cfg_b.latch = st.ctrl[CTRL_LATCH_B];
   assign cfg_b.pipe = st.ctrl[CTRL_PIPE_B];
   assign cfg_b.casc = st.ctrl[CTRL_CASC_B];

   // either the pin or software may gate the array
   assign sleep_now = sleep_in || st.ctrl[CTRL_SLEEP];

   // split: a owns the lower 18Kb half, b the upper half
   always_comb begin
      addr_a = mreq_a.addr;
      addr_b = mreq_b.addr;
      if (st.ctrl[CTRL_SPLIT]) begin
         addr_a[ADDR_W-1] = 1'b0;
         addr_b[ADDR_W-1] = 1'b1;
      end
   end

   // a same-word double write is undefined for users; a wins here
   assign clash = !sleep_now && mreq_a.en && mreq_a.we && mreq_b.en &&
      mreq_b.we && (addr_a == addr_b);

   // two instances with nothing shared but the array
   dpbr_port u_port_a (
      .aclk(aclk),
      .aresetn(aresetn),
      .cfg(cfg_a),
      .req(req_a),
      .mem_dout(mdout_a),
      .casc_din(casc_din_a),
      .mem_req(mreq_a),
      .casc_req(casc_req_a),
      .dout(dout_a)
   );

   dpbr_port u_port_b (
      .aclk(aclk),
      .aresetn(aresetn),
      .cfg(cfg_b),
      .req(req_b),
      .mem_dout(mdout_b),
      .casc_din(casc_din_b),
      .mem_req(mreq_b),
      .casc_req(casc_req_b),
      .dout(dout_b)
   );

   dpbr_mem #(
      .DW(DATA_W),
      .AW(ADDR_W)
   ) u_mem (
      .clk(aclk),
      .rst_n(aresetn),
      .sleep(sleep_now),
      .en_a(mreq_a.en),
      .we_a(mreq_a.we),
      .addr_a(addr_a),
      .din_a(mreq_a.din),
      .wm_a(dpbr_wmode_t'(st.ctrl[CTRL_WM_A +: 2])),
      .en_b(mreq_b.en),
      .we_b(mreq_b.we),
      .addr_b(addr_b),
      .din_b(mreq_b.din),
      .wm_b(dpbr_wmode_t'(st.ctrl[CTRL_WM_B +: 2])),
      .dout_a(mdout_a),
      .dout_b(mdout_b)
   );

   // the bus accepts address and data in either order
   assign s_axi_awready = !st.aw_full && !st.bvalid;
   assign s_axi_wready = !st.w_full && !st.bvalid;
   assign s_axi_arready = !st.rvalid;
   assign s_axi_bvalid = st.bvalid;
   assign s_axi_bresp = st.bresp;
   assign s_axi_rvalid = st.rvalid;
   assign s_axi_rresp = st.rresp;
   assign s_axi_rdata = st.rdata;
   assign sleep_active = st.sleep_q;

   assign wr_go = st.aw_full && st.w_full && !st.bvalid;
   assign ar_go = s_axi_arvalid && !st.rvalid;

   always_comb begin
      ctrl_word = '0;
      ctrl_word[CTRL_BITS-1:0] = st.ctrl;
      stat_word = '0;
      stat_word[STAT_SLEEP] = st.sleep_q;
      stat_word[STAT_COLL] = st.coll;
      stat_word[STAT_SPLIT] = st.ctrl[CTRL_SPLIT];
   end

   // byte strobes become a bit mask over the write data
   for (genvar i = 0; i < 4; i++) begin : g_strb
      assign wmask[8*i +: 8] = {8{st.w_strb[i]}};
   end

   always_comb begin
      next_st = st;
      next_st.sleep_q = sleep_now;
      if (s_axi_awvalid && s_axi_awready) begin
         next_st.aw_full = 1'b1;
         next_st.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_st.w_full = 1'b1;
         next_st.w_data = s_axi_wdata;
         next_st.w_strb = s_axi_wstrb;
      end
      if (st.bvalid && s_axi_bready) begin
         next_st.bvalid = 1'b0;
      end
      if (wr_go) begin
         next_st.aw_full = 1'b0;
         next_st.w_full = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = RESP_OKAY;
         unique case ({st.aw_addr[REG_AW-1:2], 2'b00})
            REG_CTRL: begin
               next_st.ctrl = (st.ctrl & ~wmask[CTRL_BITS-1:0]) |
                  (st.w_data[CTRL_BITS-1:0] & wmask[CTRL_BITS-1:0]);
            end
            REG_STATUS: begin
               // write one to clear the clash flag
               if (st.w_data[STAT_COLL] && st.w_strb[0]) begin
                  next_st.coll = 1'b0;
               end
            end
            REG_COLL_ADDR: begin
               next_st.bresp = RESP_OKAY;
            end
            default: next_st.bresp = RESP_SLVERR;
         endcase
      end
      // a new clash beats a clear in the same cycle
      if (clash) begin
         next_st.coll = 1'b1;
         next_st.coll_addr = addr_a;
      end
      if (st.rvalid && s_axi_rready) begin
         next_st.rvalid = 1'b0;
      end
      if (ar_go) begin
         next_st.rvalid = 1'b1;
         next_st.rresp = RESP_OKAY;
         unique case ({s_axi_araddr[REG_AW-1:2], 2'b00})
            REG_CTRL: next_st.rdata = ctrl_word;
            REG_STATUS: next_st.rdata = stat_word;
            REG_COLL_ADDR: begin
               next_st.rdata = 32'h0000_0000;
               next_st.rdata[ADDR_W-1:0] = st.coll_addr;
            end
            default: begin
               next_st.rdata = 32'h0000_0000;
               next_st.rresp = RESP_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
         st.ctrl <= CTRL_RST;
      end else begin
         st <= next_st;
      end
   end

endmodule : dpbr_top

// ### tb/dpbr_chk.sv
// port assertions of the dual-port block memory
`timescale 1ns/10ps
module dpbr_chk
   import dpbr_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic sleep_in,
   input wire logic sleep_active,
   input wire dpbr_req_t req_a,
   input wire dpbr_req_t req_b,
   input wire dpbr_req_t casc_req_a,
   input wire dpbr_req_t casc_req_b,
   input wire logic [DATA_W-1:0] dout_a,
   input wire logic [DATA_W-1:0] dout_b,
   input wire logic [DATA_W-1:0] casc_din_a,
   input wire logic [DATA_W-1:0] casc_din_b
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sleep_track_a: assert property (sleep_in |=> sleep_active)
      else $error("sleep flag missed the pin");
   sleep_hold_a: assert property (
      sleep_in [*3] |-> $stable(dout_a))
      else $error("port a output moved while asleep");
   sleep_hold_b: assert property (
      sleep_in [*3] |-> $stable(dout_b))
      else $error("port b output moved while asleep");
   // register writes may move the output mux, so they are left out
   idle_hold_a: assert property (
      (!req_a.en && !s_axi_wvalid) [*4] ##0 $stable(casc_din_a)
      |-> $stable(dout_a))
      else $error("port a output moved without access");
   idle_hold_b: assert property (
      (!req_b.en && !s_axi_wvalid) [*4] ##0 $stable(casc_din_b)
      |-> $stable(dout_b))
      else $error("port b output moved without access");
   casc_fwd_a: assert property (
      casc_req_a.en |-> $past(req_a.en) && $past(req_a.upper)
      && casc_req_a.addr == $past(req_a.addr))
      else $error("port a cascade request not from input");
   casc_fwd_b: assert property (
      casc_req_b.en |-> $past(req_b.upper)
      && casc_req_b.din == $past(req_b.din))
      else $error("port b cascade request not from input");
   read_resp_a: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer late");

   cover property (casc_req_a.en);
   cover property (sleep_in ##1 sleep_active);
   cover property (s_axi_arvalid && s_axi_arready);
endmodule : dpbr_chk

bind dpbr_top dpbr_chk chk (.aclk, .aresetn, .s_axi_wvalid, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid, .sleep_in, .sleep_active, .req_a, .req_b,
   .casc_req_a, .casc_req_b, .dout_a, .dout_b, .casc_din_a, .casc_din_b);

// ### tb/dpbr_nbr.sv
// cascade neighbour: a second memory block serving both ports
`timescale 1ns/10ps
module dpbr_nbr
   import dpbr_pkg::*;
(
   input wire logic aclk,
   input wire dpbr_req_t req_a,
   input wire dpbr_req_t req_b,
   output logic [DATA_W-1:0] dout_a,
   output logic [DATA_W-1:0] dout_b
);
   logic [DATA_W-1:0] mem [1024];

   initial begin
      dout_a = '0;
      dout_b = '0;
   end

   // request arrives registered, so one array cycle lines up with the block
   always @(posedge aclk) begin
      if (req_a.en) begin
         dout_a <= req_a.we ? req_a.din : mem[req_a.addr];
         if (req_a.we)
            mem[req_a.addr] <= req_a.din;
      end
      if (req_b.en) begin
         dout_b <= req_b.we ? req_b.din : mem[req_b.addr];
         if (req_b.we)
            mem[req_b.addr] <= req_b.din;
      end
   end
endmodule : dpbr_nbr

// ### tb/testbench.sv
// self-checking bench of the dual-port block memory
`timescale 1ns/10ps
module testbench
   import dpbr_pkg::*;
;
   logic aclk, aresetn, sleep_in, sleep_active;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic [REG_AW-1:0] s_axi_awaddr, s_axi_araddr;
   logic [2:0] s_axi_awprot, s_axi_arprot;
   logic [31:0] s_axi_wdata, s_axi_rdata, seed;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   dpbr_req_t req_a, req_b, casc_req_a, casc_req_b;
   logic [DATA_W-1:0] dout_a, dout_b, casc_din_a, casc_din_b, d;
   logic [DATA_W-1:0] ref_mem [1024];
   logic [DATA_W-1:0] last [2];
   logic [9:0] ad;
   int errors, compares;

   dpbr_top uut (.*);
   dpbr_nbr nbr (.aclk, .req_a(casc_req_a), .req_b(casc_req_b),
      .dout_a(casc_din_a), .dout_b(casc_din_b));

   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end

   function automatic logic [31:0] lfsr(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   function automatic logic [DATA_W-1:0] wexp(logic [1:0] m,
      logic [DATA_W-1:0] o, logic [DATA_W-1:0] n, logic [DATA_W-1:0] h);
      return m == 2'h0 ? n : (m == 2'h1 ? o : h);
   endfunction : wexp

   task automatic print_verdict;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : print_verdict

   task automatic chk(string nm, logic [DATA_W-1:0] x, logic [DATA_W-1:0] g);
      compares++;
      if (g !== x) begin
         errors++;
         $display("ERROR %s expected %h seen %h", nm, x, g);
      end
   endtask : chk

   task automatic hang(int n);
      if (n > 40) begin
         errors++;
         print_verdict();
      end
   endtask : hang

   task automatic wr(logic [REG_AW-1:0] a, logic [31:0] v, logic [1:0] r);
      int n;
      logic ta, tw, tb;
      n = 0;
      tb = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!tb) begin
         @(negedge aclk);
         ta = s_axi_awvalid & s_axi_awready;
         tw = s_axi_wvalid & s_axi_wready;
         tb = s_axi_bvalid;
         if (tb)
            chk("bresp", {34'h0, r}, {34'h0, s_axi_bresp});
         @(posedge aclk);
         if (ta)
            s_axi_awvalid <= 1'b0;
         if (tw)
            s_axi_wvalid <= 1'b0;
         hang(++n);
      end
   endtask : wr

   task automatic rd(logic [REG_AW-1:0] a, logic [31:0] v, logic [1:0] r);
      int n;
      logic ta, tr;
      n = 0;
      tr = 1'b0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      while (!tr) begin
         @(negedge aclk);
         ta = s_axi_arvalid & s_axi_arready;
         tr = s_axi_rvalid;
         if (tr)
            chk("rdata", {2'h0, r, v}, {2'h0, s_axi_rresp, s_axi_rdata});
         @(posedge aclk);
         if (ta)
            s_axi_arvalid <= 1'b0;
         hang(++n);
      end
   endtask : rd

   // one access; the output must still hold its old value one cycle before its latency is up
   task automatic op(bit p, bit w, bit u, logic [9:0] a,
      logic [DATA_W-1:0] x, logic [DATA_W-1:0] v, int lat);
      @(posedge aclk);
      if (p)
         req_b <= {1'b1, w, u, a, x};
      else
         req_a <= {1'b1, w, u, a, x};
      @(posedge aclk);
      if (p)
         req_b.en <= 1'b0;
      else
         req_a.en <= 1'b0;
      repeat (lat - 2) @(posedge aclk);
      @(negedge aclk);
      chk("dout early", last[p], p ? dout_b : dout_a);
      @(posedge aclk);
      @(negedge aclk);
      chk("dout", v, p ? dout_b : dout_a);
      last[p] = v;
   endtask : op

   initial begin
      errors = 0;
      compares = 0;
      seed = 32'h9ca8;
      aresetn = 1'b0;
      sleep_in = 1'b0;
      req_a = '0;
      req_b = '0;
      s_axi_awvalid = 1'b0;
      s_axi_wvalid = 1'b0;
      s_axi_arvalid = 1'b0;
      s_axi_awaddr = '0;
      s_axi_araddr = '0;
      s_axi_wdata = '0;
      s_axi_awprot = 3'h0;
      s_axi_arprot = 3'h0;
      s_axi_wstrb = 4'hf;
      s_axi_bready = 1'b1;
      s_axi_rready = 1'b1;
      last = '{default: '0};
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      rd(REG_CTRL, {20'h0, CTRL_RST}, RESP_OKAY);
      rd(REG_STATUS, 32'h0, RESP_OKAY);
      rd(12'h010, 32'h0, RESP_SLVERR);
      wr(12'h010, 32'h0, RESP_SLVERR);
      $display("test registers done");
      // ports take turns, so no same-word double write here
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         ad = seed[9:0];
         d = {seed[3:0], seed};
         op(i[0], 1, 0, ad, d, d, 2);
         ref_mem[ad] = d;
         op(!i[0], 0, 0, ad, 0, d, 2);
      end
      $display("test shared array done");
      for (int m = 0; m < 3; m++) begin
         wr(REG_CTRL, 32'h00c | (m << 6), RESP_OKAY);
         seed = lfsr(seed);
         d = {4'h0, seed};
         op(0, 1, 0, ad, d, wexp(m[1:0], ref_mem[ad], d, last[0]), 2);
         ref_mem[ad] = d;
      end
      $display("test write modes done");
      wr(REG_CTRL, 32'h03c, RESP_OKAY);
      d = {seed, 4'h5};
      op(1, 1, 0, ad, d, d, 3);
      op(0, 0, 0, ad, 0, d, 3);
      ref_mem[ad] = d;
      $display("test pipeline done");
      wr(REG_CTRL, 32'h00c, RESP_OKAY);
      sleep_in <= 1'b1;
      op(0, 1, 0, ad, ~d, last[0], 2);
      chk("sleep_active", 36'h1, {35'h0, sleep_active});
      @(posedge aclk);
      sleep_in <= 1'b0;
      op(0, 0, 0, ad, 0, d, 2);
      wr(REG_CTRL, 32'h00e, RESP_OKAY);
      rd(REG_STATUS, 32'h1, RESP_OKAY);
      $display("test sleep done");
      wr(REG_CTRL, 32'h00d, RESP_OKAY);
      op(0, 1, 0, 10'h205, d, d, 2);
      op(1, 1, 0, 10'h005, ~d, ~d, 2);
      wr(REG_CTRL, 32'h00c, RESP_OKAY);
      op(1, 0, 0, 10'h005, 0, d, 2);
      op(0, 0, 0, 10'h205, 0, ~d, 2);
      ref_mem[10'h005] = d;
      ref_mem[10'h205] = ~d;
      $display("test split done");
      wr(REG_CTRL, 32'hc0c, RESP_OKAY);
      op(0, 1, 1, ad, ~d, ~d, 2);
      op(1, 0, 1, ad, 0, ~d, 2);
      op(0, 0, 0, ad, 0, ref_mem[ad], 2);
      $display("test cascade done");
      @(posedge aclk);
      req_a <= {1'b1, 1'b1, 1'b0, 10'h3a7, d};
      req_b <= {1'b1, 1'b1, 1'b0, 10'h3a7, ~d};
      @(posedge aclk);
      req_a.en <= 1'b0;
      req_b.en <= 1'b0;
      op(1, 0, 0, 10'h3a7, 0, d, 2);
      rd(REG_STATUS, 32'h2, RESP_OKAY);
      rd(REG_COLL_ADDR, 32'h3a7, RESP_OKAY);
      wr(REG_STATUS, 32'h2, RESP_OKAY);
      rd(REG_STATUS, 32'h0, RESP_OKAY);
      $display("test clash done");
      print_verdict();
   end
endmodule : testbench
